// ---- core/usart_core.sv ----
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Function
// - receive interrupt priority bit selects level
// - receive flag sets; interrupt needs both enables
// - status shows errors and ninth bit
// - clearing continuous receive clears errors
// - address detect off passes every word
// - synchronous master link is transmit only; the receiver is held off in sync mode
// - clocked-mode select enters synchronous mode
// - port enable turns pins into clock, data
// - clock source select drives shift clock
// - shift register reloads after last bit
// - buffer to shifter in one cycle, flag sets
// - buffer-empty flag cleared by buffer write or by clearing transmit enable
// - transmit enable gates buffer-empty interrupt
// - shift-register-empty readable, polled only
// - shift register is not mapped
// - buffer write starts transmission when enabled
// - async frame start, 8/9 data, stop, lsb first
// - baud tick once per async bit, after 16 or 64 divider periods
module usart_core (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clockLineIn,
    output logic clockLineOut,
    output logic clockLineOeN,
    input wire logic dataLineIn,
    output logic dataLineOut,
    output logic dataLineOeN,
    output logic intHigh,
    output logic intLow
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] intCtl_ff, pEn_ff, pPrio_ff, baud_ff, txBuf_ff, rxBuf_ff;
    logic [6:0] rxCtl_ff;
    logic [7:0] txCtl_ff;
    logic txFull_ff, rxFlag_ff, framing_error_flag_ff, overrun_error_flag_ff, received_ninth_bit_ff;
    logic [8:0] tsr_ff;
    logic [3:0] txCnt_ff;
    logic tsrBusy_ff, txLoad_ff;
    logic [7:0] brg_ff;
    logic [6:0] ovs_ff;
    logic tick;
    logic [9:0] rsr_ff;
    logic [3:0] rxCnt_ff;
    logic [6:0] rxPh_ff;
    logic rxBusy_ff, rxDone;
    logic rxIn_ff;

    logic wrEn, rdEn;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;

    logic serial_port_enable, sync, clock_source_select, transmit_enable, continuous_receive_enable, address_detect_enable, rx9, tx9, master;
    assign serial_port_enable = rxCtl_ff[usart_pkg::SERIAL_PORT_ENABLE_BIT - 1];
    assign rx9 = rxCtl_ff[usart_pkg::RX9_BIT - 1];
    assign continuous_receive_enable = rxCtl_ff[usart_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT - 1];
    assign address_detect_enable = rxCtl_ff[usart_pkg::ADDRESS_DETECT_ENABLE_BIT - 1];
    assign sync = txCtl_ff[usart_pkg::SYNC_BIT];
    assign clock_source_select = txCtl_ff[usart_pkg::CLOCK_SOURCE_SELECT_BIT];
    assign transmit_enable = txCtl_ff[usart_pkg::TRANSMIT_ENABLE_BIT];
    assign tx9 = txCtl_ff[usart_pkg::TX9_BIT];
    assign master = serial_port_enable && sync && clock_source_select;

    ////////////////////////////////////////////////////////////////////////
    // bus slave, zero wait states
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            intCtl_ff <= usart_pkg::REG_RST;
            pEn_ff <= usart_pkg::REG_RST;
            pPrio_ff <= usart_pkg::REG_RST;
            baud_ff <= usart_pkg::REG_RST;
            rxCtl_ff <= 7'h00;
            txCtl_ff <= usart_pkg::TXSTAT_RST;
        end else if (wrEn && pready) begin
            case (paddr)
                usart_pkg::ADDR_INTCTL: intCtl_ff <= pwdata[7:0];
                usart_pkg::ADDR_PENABLES: pEn_ff <= pwdata[7:0];
                usart_pkg::ADDR_PPRIO: pPrio_ff <= pwdata[7:0];
                usart_pkg::ADDR_BAUD: baud_ff <= pwdata[7:0];
                usart_pkg::ADDR_RXSTAT: rxCtl_ff <= pwdata[7:1];
                // status bit 1 stays hardware owned
                usart_pkg::ADDR_TXSTAT: txCtl_ff <= {pwdata[7:2], 1'b0, pwdata[0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                usart_pkg::ADDR_INTCTL: prdata <= {24'h00_0000, intCtl_ff};
                usart_pkg::ADDR_PFLAGS:
                    prdata <= {24'h00_0000, 2'b00, rxFlag_ff, !txFull_ff && transmit_enable, 4'h0};
                usart_pkg::ADDR_PENABLES: prdata <= {24'h00_0000, pEn_ff};
                usart_pkg::ADDR_PPRIO: prdata <= {24'h00_0000, pPrio_ff};
                usart_pkg::ADDR_RXSTAT:
                    prdata <= {24'h00_0000, rxCtl_ff[6:2], framing_error_flag_ff, overrun_error_flag_ff, received_ninth_bit_ff};
                usart_pkg::ADDR_RXDATA: prdata <= {24'h00_0000, rxBuf_ff};
                usart_pkg::ADDR_TXSTAT:
                    prdata <= {24'h00_0000, txCtl_ff[7:4], 1'b0, txCtl_ff[2],
                               !tsrBusy_ff, txCtl_ff[0]};
                usart_pkg::ADDR_BAUD: prdata <= {24'h00_0000, baud_ff};
                usart_pkg::ADDR_TXDATA: prdata <= {24'h00_0000, txBuf_ff};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud tick; sync mode divides by a fixed eight per half bit
    always_ff @(posedge mclk) begin
        if (rst) begin
            brg_ff <= 8'h00;
            ovs_ff <= 7'h00;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (brg_ff == 8'h00) begin
                brg_ff <= baud_ff;
                if (ovs_ff == 7'h00) begin
                    tick <= 1'b1;
                    ovs_ff <= (sync ? usart_pkg::OVS_MID
                               : (txCtl_ff[usart_pkg::HIGH_SPEED_BAUD_SELECT_BIT] ? usart_pkg::OVS_HIGH
                                  : usart_pkg::OVS_LOW)) - 7'h01;
                end else begin
                    ovs_ff <= ovs_ff - 7'h01;
                end
            end else begin
                brg_ff <= brg_ff - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer: flag is the inverse of full while transmit enable is set; a write or clearing transmit enable clears it
    always_ff @(posedge mclk) begin
        if (rst) begin
            txBuf_ff <= usart_pkg::REG_RST;
            txFull_ff <= 1'b0;
        end else if (wrEn && pready && paddr == usart_pkg::ADDR_TXDATA) begin
            txBuf_ff <= pwdata[7:0];
            txFull_ff <= 1'b1;
        end else if (txLoad_ff) begin
            txFull_ff <= 1'b0;
        end
    end

    // shift register; private, no bus path reaches it
    logic [3:0] txBits;
    // sync needs one extra count so the last bit still gets its rising clock
    assign txBits = sync ? (tx9 ? 4'd10 : 4'd9) : (tx9 ? 4'd11 : 4'd10);
    logic clkPh_ff;
    logic txOut_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            tsr_ff <= 9'h1FF;
            txCnt_ff <= 4'h0;
            tsrBusy_ff <= 1'b0;
            txLoad_ff <= 1'b0;
            clkPh_ff <= 1'b1;
            txOut_ff <= 1'b1;
        end else begin
            txLoad_ff <= 1'b0;
            if (!tsrBusy_ff && txFull_ff && transmit_enable && serial_port_enable && !txLoad_ff && !rxBusy_ff) begin
                tsr_ff <= {txCtl_ff[usart_pkg::TRANSMIT_NINTH_BIT_BIT], txBuf_ff};
                tsrBusy_ff <= 1'b1;
                txLoad_ff <= 1'b1;
                txCnt_ff <= txBits;
                clkPh_ff <= 1'b1;
                if (!sync) begin
                    txOut_ff <= 1'b0;
                end
            end else if (tsrBusy_ff && tick) begin
                clkPh_ff <= !clkPh_ff;
                if (!sync || clkPh_ff) begin
                    if (txCnt_ff == 4'h1) begin
                        tsrBusy_ff <= 1'b0;
                        txOut_ff <= 1'b1;
                    end else begin
                        if (sync || txCnt_ff > 4'h2) begin
                            txOut_ff <= tsr_ff[0];
                            tsr_ff <= {1'b1, tsr_ff[8:1]};
                        end else begin
                            txOut_ff <= 1'b1;
                        end
                    end
                    txCnt_ff <= txCnt_ff - 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: enable low drives
    always_ff @(posedge mclk) begin
        if (rst) begin
            clockLineOut <= 1'b1;
            clockLineOeN <= 1'b1;
            dataLineOeN <= 1'b1;
            dataLineOut <= 1'b1;
        end else begin
            // async frames leave on the clock pin; the data pin stays free for rx
            clockLineOut <= master ? (tsrBusy_ff ? clkPh_ff : 1'b1)
                                   : (sync ? 1'b1 : txOut_ff);
            clockLineOeN <= !((serial_port_enable && !sync) || master);
            dataLineOeN <= !(serial_port_enable && sync && tsrBusy_ff);
            // registered with the clock pin so data only moves as the clock falls
            dataLineOut <= txOut_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // async receiver, sampled mid bit
    logic [3:0] rxBits;
    assign rxBits = rx9 ? 4'd10 : 4'd9;
    always_ff @(posedge mclk) begin
        if (rst) begin
            rxIn_ff <= 1'b1;
        end else begin
            rxIn_ff <= dataLineIn;
        end
    end

    logic [7:0] rxOvs;
    assign rxOvs = {1'b0, txCtl_ff[usart_pkg::HIGH_SPEED_BAUD_SELECT_BIT] ? usart_pkg::OVS_HIGH
                                                      : usart_pkg::OVS_LOW};
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsr_ff <= 10'h000;
            rxCnt_ff <= 4'h0;
            rxPh_ff <= 7'h00;
            rxBusy_ff <= 1'b0;
            rxDone <= 1'b0;
        end else begin
            rxDone <= 1'b0;
            if (!serial_port_enable || sync || !continuous_receive_enable || tsrBusy_ff) begin
                rxBusy_ff <= 1'b0;
            end else if (!rxBusy_ff) begin
                if (!rxIn_ff) begin
                    rxBusy_ff <= 1'b1;
                    rxPh_ff <= rxOvs[7:1] - 7'h01;
                    rxCnt_ff <= rxBits;
                end
            end else if (brg_ff == 8'h00) begin
                if (rxPh_ff == 7'h00) begin
                    rxPh_ff <= rxOvs[6:0] - 7'h01;
                    rsr_ff <= {rxIn_ff, rsr_ff[9:1]};
                    rxCnt_ff <= rxCnt_ff - 4'h1;
                    if (rxCnt_ff == 4'h0) begin
                        rxBusy_ff <= 1'b0;
                        rxDone <= 1'b1;
                    end
                end else begin
                    rxPh_ff <= rxPh_ff - 7'h01;
                end
            end
        end
    end

    // word layout in rsr after the stop bit: stop at top
    logic [8:0] rxWord;
    logic rxStop;
    assign rxWord = rx9 ? rsr_ff[8:0] : {1'b0, rsr_ff[8:1]};
    assign rxStop = rsr_ff[9];
    logic rxAccept;
    assign rxAccept = !(address_detect_enable && rx9) || rxWord[8];
    logic rxRead;
    assign rxRead = rdEn && pready && paddr == usart_pkg::ADDR_RXDATA;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rxBuf_ff <= usart_pkg::REG_RST;
            rxFlag_ff <= 1'b0;
            framing_error_flag_ff <= 1'b0;
            overrun_error_flag_ff <= 1'b0;
            received_ninth_bit_ff <= 1'b0;
        end else begin
            if (rxDone && rxAccept) begin
                if (rxFlag_ff && !rxRead) begin
                    overrun_error_flag_ff <= 1'b1;
                end else begin
                    rxBuf_ff <= rxWord[7:0];
                    received_ninth_bit_ff <= rxWord[8];
                    framing_error_flag_ff <= !rxStop;
                    rxFlag_ff <= 1'b1;
                end
            end else if (rxRead) begin
                rxFlag_ff <= 1'b0;
            end
            if (!continuous_receive_enable && !(rxDone && rxAccept)) begin
                overrun_error_flag_ff <= 1'b0;
                framing_error_flag_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic txIrq, rxIrq, global_int_enable;
    assign global_int_enable = intCtl_ff[usart_pkg::GIE_BIT];
    assign txIrq = pEn_ff[usart_pkg::TXF_BIT] && !txFull_ff && transmit_enable;
    assign rxIrq = pEn_ff[usart_pkg::RXF_BIT] && rxFlag_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            intHigh <= 1'b0;
            intLow <= 1'b0;
        end else begin
            intHigh <= global_int_enable && ((rxIrq && pPrio_ff[usart_pkg::RXF_BIT])
                               || (txIrq && pPrio_ff[usart_pkg::TXF_BIT]));
            intLow <= global_int_enable && ((rxIrq && !pPrio_ff[usart_pkg::RXF_BIT])
                              || (txIrq && !pPrio_ff[usart_pkg::TXF_BIT]));
        end
    end

endmodule

// ---- inc/usart_pkg.sv ----
package usart_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_INTCTL = 8'h00;
    localparam logic [7:0] ADDR_PFLAGS = 8'h04;
    localparam logic [7:0] ADDR_PENABLES = 8'h08;
    localparam logic [7:0] ADDR_PPRIO = 8'h0C;
    localparam logic [7:0] ADDR_RXSTAT = 8'h10;
    localparam logic [7:0] ADDR_RXDATA = 8'h14;
    localparam logic [7:0] ADDR_TXSTAT = 8'h18;
    localparam logic [7:0] ADDR_BAUD = 8'h1C;
    localparam logic [7:0] ADDR_TXDATA = 8'h20;
    // field positions
    localparam int GIE_BIT = 7;
    localparam int RXF_BIT = 5;
    localparam int TXF_BIT = 4;
    localparam int SERIAL_PORT_ENABLE_BIT = 7;
    localparam int RX9_BIT = 6;
    localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
    localparam int FRAMING_ERROR_FLAG_BIT = 2;
    localparam int OVERRUN_ERROR_FLAG_BIT = 1;
    localparam int RECEIVED_NINTH_BIT_BIT = 0;
    localparam int CLOCK_SOURCE_SELECT_BIT = 7;
    localparam int TX9_BIT = 6;
    localparam int TRANSMIT_ENABLE_BIT = 5;
    localparam int SYNC_BIT = 4;
    localparam int HIGH_SPEED_BAUD_SELECT_BIT = 2;
    localparam int SHIFT_REGISTER_EMPTY_BIT = 1;
    localparam int TRANSMIT_NINTH_BIT_BIT = 0;
    // reset values
    localparam logic [7:0] TXSTAT_RST = 8'h02;
    localparam logic [7:0] REG_RST = 8'h00;
    // oversampling ratios
    localparam logic [6:0] OVS_HIGH = 7'h10;
    localparam logic [6:0] OVS_LOW = 7'h40;
    localparam logic [6:0] OVS_MID = 7'h08;
endpackage

// ---- sim/usart_core_props.sv ----
`timescale 1ns/1ps
module usart_core_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic clockLineIn,
    input wire logic clockLineOut,
    input wire logic clockLineOeN,
    input wire logic dataLineIn,
    input wire logic dataLineOut,
    input wire logic dataLineOeN,
    input wire logic intHigh,
    input wire logic intLow
);
    logic [7:0] txSh_ff;
    logic [7:0] rxSh_ff;
    logic [7:0] enSh_ff;
    logic mstr;
    logic ie;
    // shadows of software writes, so pin behaviour can be tied to its cause
    always_ff @(posedge mclk) begin
        if (rst) begin
            txSh_ff <= usart_pkg::TXSTAT_RST;
            rxSh_ff <= usart_pkg::REG_RST;
            enSh_ff <= usart_pkg::REG_RST;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == usart_pkg::ADDR_TXSTAT) txSh_ff <= pwdata[7:0];
            if (paddr == usart_pkg::ADDR_RXSTAT) rxSh_ff <= pwdata[7:0];
            if (paddr == usart_pkg::ADDR_PENABLES) enSh_ff <= pwdata[7:0];
        end
    end
    assign mstr = txSh_ff[usart_pkg::CLOCK_SOURCE_SELECT_BIT] && rxSh_ff[usart_pkg::SERIAL_PORT_ENABLE_BIT];
    assign ie = enSh_ff[usart_pkg::RXF_BIT] || enSh_ff[usart_pkg::TXF_BIT];
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_PHASE: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    AST_NO_ERR: assert property (!pslverr)
        else $error("slave error raised");
    AST_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == '0)
        else $error("upper read bits set");
    AST_HOLD: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved without a read");
    AST_RESET: assert property ($fell(rst) |-> clockLineOeN && dataLineOeN && !pready && !intHigh)
        else $error("outputs not at reset level");
    AST_MASTER: assert property (
        !clockLineOeN && txSh_ff[usart_pkg::SYNC_BIT] |-> mstr || $past(mstr))
        else $error("clock driven outside master mode");
    AST_CLK_RATE: assert property (
        $changed(clockLineOut) && !clockLineOeN |=> $stable(clockLineOut) [* 7])
        else $error("shift clock too fast");
    AST_DATA_EDGE: assert property ($changed(dataLineOut) && !dataLineOeN &&
        $past(!dataLineOeN) && txSh_ff[usart_pkg::SYNC_BIT] |-> !clockLineOut)
        else $error("data moved while clock high");
    AST_INT_GATE: assert property ((intHigh || intLow) |-> ie || $past(ie))
        else $error("interrupt without enable");
    cover property (pready && pwrite && paddr == usart_pkg::ADDR_TXDATA);
    cover property (intHigh);
    cover property (!clockLineOeN && $fell(clockLineOut));
endmodule
bind usart_core usart_core_props u_props (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clockLineIn(clockLineIn),
    .clockLineOut(clockLineOut), .clockLineOeN(clockLineOeN), .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN), .intHigh(intHigh),
    .intLow(intLow));

// ---- sim/usart_peer.sv ----
`timescale 1ns/1ps
module usart_peer (
    input wire logic mclk,
    input wire logic clockLineOut,
    input wire logic clockLineOeN,
    input wire logic dataLineOut,
    input wire logic dataLineOeN,
    output logic peerTx
);
    logic [15:0] capBits = '0;
    int capCount = 0;
    initial peerTx = 1'b1;
    // data moves while the clock is low, so the rising edge is the safe sample
    always @(posedge clockLineOut) begin
        if (!clockLineOeN && !dataLineOeN) begin
            capBits <= {dataLineOut, capBits[15:1]};
            capCount <= capCount + 1;
        end
    end
    task automatic sendFrame(input logic [8:0] word, input logic stopBit, input int bitTime);
        logic [10:0] frame;
        frame = {stopBit, word, 1'b0};
        for (int i = 0; i < 11; i++) begin
            peerTx <= frame[i];
            repeat (bitTime) @(posedge mclk);
        end
        peerTx <= 1'b1;
        repeat (bitTime) @(posedge mclk);
    endtask
endmodule

// ---- sim/usart_sync_master_tx_addr_detect_test.sv ----
`timescale 1ns/1ps
module usart_sync_master_tx_addr_detect_test;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, intHigh, intLow;
    logic clockLineOut, clockLineOeN, dataLineOut, dataLineOeN, peerTx, dataWire, clockWire;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    int failures = 0;
    int cmp_count = 0;
    int bt;
    // open-drain style resolution; the rx line idles high because the peer holds peerTx high
    assign dataWire = dataLineOeN ? peerTx : dataLineOut;
    assign clockWire = clockLineOeN ? 1'b1 : clockLineOut;
    usart_core dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clockLineIn(clockWire), .clockLineOut(clockLineOut), .clockLineOeN(clockLineOeN),
        .dataLineIn(dataWire), .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN),
        .intHigh(intHigh), .intLow(intLow));
    usart_peer peer (.mclk(mclk), .clockLineOut(clockLineOut), .clockLineOeN(clockLineOeN),
        .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN), .peerTx(peerTx));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge mclk);
        penable <= 1'b1;
        // look at ready mid cycle, then let the sampling edge complete the transfer
        do begin
            @(negedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
        end
        rdData = prdata;
        @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(nm, 32'(e), rdData);
    endtask
    initial begin
        #200000;
        failures++;
        results();
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        bt = int'(usart_pkg::OVS_HIGH);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            rd("reset value", 8'(i * 4), (i == 6) ? usart_pkg::TXSTAT_RST : 8'h00);
        end
        apb(1'b1, 8'h24, 8'hFF);
        rd("unmapped", 8'h24, 8'h00);
        $display("test reset done");
        apb(1'b1, usart_pkg::ADDR_BAUD, 8'h00);
        apb(1'b1, usart_pkg::ADDR_TXSTAT, 8'h90);
        apb(1'b1, usart_pkg::ADDR_RXSTAT, 8'h80);
        apb(1'b1, usart_pkg::ADDR_INTCTL, 8'h80);
        apb(1'b1, usart_pkg::ADDR_PENABLES, 8'h10);
        apb(1'b1, usart_pkg::ADDR_TXSTAT, 8'hB0);
        rd("empty flag", usart_pkg::ADDR_PFLAGS, 8'h10);
        chk("tx interrupt", 32'h0000_0001, 32'(intLow));
        apb(1'b1, usart_pkg::ADDR_TXDATA, 8'hA5);
        apb(1'b1, usart_pkg::ADDR_TXDATA, 8'h3C);
        rd("buffer full", usart_pkg::ADDR_PFLAGS, 8'h00);
        rd("shifter busy", usart_pkg::ADDR_TXSTAT, 8'hB0);
        for (int i = 0; i < 3000 && peer.capCount < 16; i++) @(posedge mclk);
        chk("shifted bits", 32'h0000_3CA5, 32'(peer.capBits));
        for (int i = 0; i < 40 && rdData[usart_pkg::SHIFT_REGISTER_EMPTY_BIT] !== 1'b1; i++) begin
            apb(1'b0, usart_pkg::ADDR_TXSTAT, 8'h00);
        end
        rd("shifter empty", usart_pkg::ADDR_TXSTAT, 8'hB2);
        apb(1'b1, usart_pkg::ADDR_PFLAGS, 8'h00);
        rd("flag kept", usart_pkg::ADDR_PFLAGS, 8'h10);
        apb(1'b1, usart_pkg::ADDR_PENABLES, 8'h00);
        @(posedge mclk);
        chk("tx interrupt masked", 32'h0000_0000, 32'(intLow));
        $display("test sync transmit done");
        apb(1'b1, usart_pkg::ADDR_TXSTAT, 8'h04);
        apb(1'b1, usart_pkg::ADDR_PENABLES, 8'h20);
        apb(1'b1, usart_pkg::ADDR_PPRIO, 8'h20);
        apb(1'b1, usart_pkg::ADDR_RXSTAT, 8'hC0);
        apb(1'b1, usart_pkg::ADDR_RXSTAT, 8'hC8);
        apb(1'b1, usart_pkg::ADDR_RXSTAT, 8'hD8);
        peer.sendFrame(9'h055, 1'b1, bt);
        rd("data word dropped", usart_pkg::ADDR_PFLAGS, 8'h00);
        peer.sendFrame(9'h1A7, 1'b1, bt);
        rd("address flag", usart_pkg::ADDR_PFLAGS, 8'h20);
        chk("rx high interrupt", 32'h0000_0001, 32'(intHigh));
        rd("rx status", usart_pkg::ADDR_RXSTAT, 8'hD9);
        rd("rx address", usart_pkg::ADDR_RXDATA, 8'hA7);
        apb(1'b1, usart_pkg::ADDR_RXSTAT, 8'hD0);
        peer.sendFrame(9'h042, 1'b1, bt);
        rd("rx flag", usart_pkg::ADDR_PFLAGS, 8'h20);
        rd("rx data", usart_pkg::ADDR_RXDATA, 8'h42);
        peer.sendFrame(9'h000, 1'b0, bt);
        rd("framing error", usart_pkg::ADDR_RXSTAT, 8'hD4);
        apb(1'b1, usart_pkg::ADDR_RXSTAT, 8'hC0);
        rd("error cleared", usart_pkg::ADDR_RXSTAT, 8'hC0);
        $display("test address detect done");
        results();
    end
endmodule
